// File: rtl/gdpc_pkg.sv
// Constants, types and helpers shared by the gate driver protection register bank
package gdpc_pkg;

  // ************************************************************
  // Clock, bus and counter widths
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DEG_W = 12;
  localparam int RETRY_W = 20;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFS_FAULT_CLEAR = 8'h04;
  localparam logic [7:0] OFS_LOCK_FAULT = 8'h0D;
  localparam logic [7:0] OFS_OC_MODE = 8'h0E;
  localparam logic [7:0] OFS_AMP_GAIN = 8'h0F;
  localparam logic [7:0] OFS_THRESH_CAL = 8'h10;
  localparam logic [7:0] OFS_AMP_CAL = 8'h11;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h12;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h13;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_LOCK_FAULT = 8'h61;
  localparam logic [7:0] RST_OC_MODE = 8'h00;
  localparam logic [7:0] RST_AMP_GAIN = 8'h2A;
  localparam logic [7:0] RST_THRESH_CAL = 8'h7F;
  localparam logic [7:0] RST_AMP_CAL = 8'h00;
  localparam logic [4:0] RST_IRQ = 5'h00;

  // ************************************************************
  // Field positions and codes
  // ************************************************************
  localparam int LOCK_MSB = 7;
  localparam int LOCK_LSB = 5;
  localparam logic [2:0] LOCK_CODE = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;
  localparam int PUMP_UV_OFF_BIT = 4;
  localparam int GATE_FAULT_OFF_BIT = 3;
  localparam int DEG_MSB = 2;
  localparam int FAULT_CLEAR_BIT = 7;
  localparam int OTW_REPORT_BIT = 6;
  localparam int CBC_BIT = 5;
  localparam int DS_OFF_C_BIT = 4;
  localparam int DS_OFF_A_BIT = 2;
  localparam int OC_MODE_MSB = 1;
  localparam int LS_GND_REF_BIT = 7;
  localparam int SENSE_DRAIN_BIT = 6;
  localparam int CAL_MODE_BIT = 7;
  localparam int REF_DIV_BIT = 6;
  localparam int CAL_MSB = 2;

  typedef enum logic [1:0] {
    OC_LATCHED,
    OC_RETRY,
    OC_REPORT_ONLY,
    OC_IGNORE
  } gdpc_oc_mode_t;

  // Status bit positions
  localparam int IRQ_OC_TRIP = 0;
  localparam int IRQ_WRITE_DROP = 1;
  localparam int IRQ_PUMP_UV = 2;
  localparam int IRQ_GATE_FAULT = 3;
  localparam int IRQ_OTW = 4;
  localparam int IRQ_W = 5;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int DEG0_NS = 2500;
  localparam int DEG1_NS = 4750;
  localparam int DEG2_NS = 6750;
  localparam int DEG3_NS = 8750;
  localparam int DEG4_NS = 10250;
  localparam int DEG5_NS = 11500;
  localparam int DEG6_NS = 16500;
  localparam int DEG7_NS = 20500;
  localparam int RETRY_TIME_US = 4000;
  localparam int RETRY_CYCLES_DEF = (RETRY_TIME_US * 1000) / CLK_PERIOD_NS;

  // Least time rounds up to whole cycles
  function automatic logic [DEG_W-1:0] gdpc_cyc(input int t_ns);
    return DEG_W'((t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  function automatic logic [DEG_W-1:0] gdpc_deg_cycles(input logic [2:0] sel);
    logic [DEG_W-1:0] c;
    c = gdpc_cyc(DEG0_NS);
    case (sel)
      3'h1: c = gdpc_cyc(DEG1_NS);
      3'h2: c = gdpc_cyc(DEG2_NS);
      3'h3: c = gdpc_cyc(DEG3_NS);
      3'h4: c = gdpc_cyc(DEG4_NS);
      3'h5: c = gdpc_cyc(DEG5_NS);
      3'h6: c = gdpc_cyc(DEG6_NS);
      3'h7: c = gdpc_cyc(DEG7_NS);
      default: c = gdpc_cyc(DEG0_NS);
    endcase
    return c;
  endfunction

  // ************************************************************
  // Analog configuration carried out to the sense amplifiers
  // ************************************************************
  typedef struct packed {
    logic low_side_ground_reference;
    logic sense_input_from_drain;
    logic [1:0] amp_gain_c;
    logic [1:0] amp_gain_b;
    logic [1:0] amp_gain_a;
    logic cal_auto_mode;
    logic ref_half;
    logic [1:0] sense_trip_level_c;
    logic [1:0] sense_trip_level_b;
    logic [1:0] sense_trip_level_a;
  } gdpc_sense_cfg_t;

endpackage

// File: rtl/gdpc_regs.sv
// Gate driver protection configuration register bank with overcurrent handling
`timescale 1ns/100ps

module gdpc_regs
  import gdpc_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [2:0] drain_source_overcurrent_i,
  input wire logic [2:0] resistor_overcurrent_i,
  input wire logic [2:0] pwm_i,
  input wire logic pump_undervolt_i,
  input wire logic gate_fault_i,
  input wire logic overtemp_warn_i,
  output logic fault_output_pin_n_o,
  output logic gate_shutdown_o,
  output logic [5:0] oc_fault_o,
  output logic [2:0] drain_source_monitor_en_o,
  output gdpc_sense_cfg_t sense_cfg_o,
  output logic [2:0] amp_short_inputs_o,
  output logic [2:0] amp_auto_cal_start_o,
  output logic locked_o,
  output logic irq_o
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic locked_reg;
  logic [4:0] lock_fault_reg;
  logic [7:0] oc_mode_reg;
  logic [7:0] amp_gain_reg;
  logic [7:0] thresh_cal_reg;
  logic [2:0] amp_cal_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_enable_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [2:0] pwm_prev_reg;
  logic [5:0] oc_fault_reg;
  logic gate_fault_reg;
  logic [RETRY_W-1:0] retry_cnt_reg;

  // ************************************************************
  // Address decode
  // ************************************************************
  wire hit_clear = (addr_i == OFS_FAULT_CLEAR);
  wire hit_lock = (addr_i == OFS_LOCK_FAULT);
  wire hit_mode = (addr_i == OFS_OC_MODE);
  wire hit_gain = (addr_i == OFS_AMP_GAIN);
  wire hit_thr = (addr_i == OFS_THRESH_CAL);
  wire hit_cal = (addr_i == OFS_AMP_CAL);
  wire hit_ist = (addr_i == OFS_IRQ_STATUS);
  wire hit_ien = (addr_i == OFS_IRQ_ENABLE);
  wire hit_icl = (addr_i == OFS_IRQ_CLEAR);

  wire [2:0] lock_code = wdata_i[LOCK_MSB:LOCK_LSB];
  wire cfg_wr_ok = wr_i && !locked_reg;
  wire wr_lock_cfg = cfg_wr_ok && hit_lock;
  wire wr_mode = cfg_wr_ok && hit_mode;
  wire wr_gain = cfg_wr_ok && hit_gain;
  wire wr_thr = cfg_wr_ok && hit_thr;
  wire wr_cal = cfg_wr_ok && hit_cal;
  wire wr_ien = cfg_wr_ok && hit_ien;
  wire wr_icl = wr_i && hit_icl;
  wire fault_clear = wr_i && hit_clear && wdata_i[FAULT_CLEAR_BIT];
  wire write_dropped = wr_i && locked_reg && (hit_mode || hit_gain || hit_thr || hit_cal || hit_ien);

  // ************************************************************
  // Lock state
  // ************************************************************
  wire do_lock = wr_i && hit_lock && !locked_reg && (lock_code == LOCK_CODE);
  wire do_unlock = wr_i && hit_lock && locked_reg && (lock_code == UNLOCK_CODE);
  wire locked_next = do_lock ? 1'b1 : (do_unlock ? 1'b0 : locked_reg);
  wire [2:0] lock_field = locked_reg ? LOCK_CODE : UNLOCK_CODE;

  // ************************************************************
  // Field decode
  // ************************************************************
  wire pump_uv_off = lock_fault_reg[PUMP_UV_OFF_BIT];
  wire gate_fault_off = lock_fault_reg[GATE_FAULT_OFF_BIT];
  wire [2:0] deg_sel = lock_fault_reg[DEG_MSB:0];
  wire [DEG_W-1:0] deg_limit = gdpc_deg_cycles(deg_sel);
  wire otw_report = oc_mode_reg[OTW_REPORT_BIT];
  wire cbc_en = oc_mode_reg[CBC_BIT];
  wire [2:0] ds_off = oc_mode_reg[DS_OFF_C_BIT:DS_OFF_A_BIT];
  gdpc_oc_mode_t oc_mode;
  assign oc_mode = gdpc_oc_mode_t'(oc_mode_reg[OC_MODE_MSB:0]);
  wire cal_auto = thresh_cal_reg[CAL_MODE_BIT];

  // Drain input select forces the ground reference bit when written
  wire [7:0] gain_wdata = {wdata_i[LS_GND_REF_BIT] | wdata_i[SENSE_DRAIN_BIT], wdata_i[6:0]};

  // ************************************************************
  // Overcurrent deglitch, one channel per source
  // ************************************************************
  wire [5:0] oc_raw = {resistor_overcurrent_i, drain_source_overcurrent_i & ~ds_off};
  wire [5:0] oc_trip;
  wire oc_accept = (oc_mode != OC_IGNORE);

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_deg
      logic [DEG_W-1:0] cnt_reg;
      wire [DEG_W-1:0] cnt_next;
      // Count only while the condition holds without a break
      assign cnt_next = !oc_raw[g] ? '0 : ((cnt_reg == deg_limit) ? cnt_reg : DEG_W'(cnt_reg + 1'b1));
      assign oc_trip[g] = oc_raw[g] && (cnt_reg == DEG_W'(deg_limit - 1'b1));
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Fault latching, retry and cycle-by-cycle clearing
  // ************************************************************
  wire pwm_edge = |(pwm_i & ~pwm_prev_reg);
  wire in_retry = (oc_mode == OC_RETRY);
  wire retry_busy = in_retry && (|oc_fault_reg);
  wire retry_done = retry_busy && (retry_cnt_reg == RETRY_W'(RETRY_CYCLES - 1));
  wire cbc_clear = in_retry && cbc_en && pwm_edge;
  wire oc_clear = fault_clear || retry_done || cbc_clear;
  wire [5:0] oc_set = oc_accept ? oc_trip : 6'h00;
  // A trip in the clearing cycle still sets the fault
  wire [5:0] oc_fault_next = oc_set | (oc_fault_reg & ~{6{oc_clear}});
  wire [RETRY_W-1:0] retry_next = (!retry_busy || retry_done) ? '0 : RETRY_W'(retry_cnt_reg + 1'b1);

  wire pump_uv_fault = pump_undervolt_i && !pump_uv_off;
  wire gate_set = gate_fault_i && !gate_fault_off;
  wire gate_fault_next = gate_set | (gate_fault_reg & ~fault_clear);
  wire otw_fault = overtemp_warn_i && otw_report;

  // Latched and retry modes act, report-only does not
  wire oc_acts = (oc_mode == OC_LATCHED) || (oc_mode == OC_RETRY);
  wire any_oc = |oc_fault_reg;
  wire fault_any = any_oc || pump_uv_fault || gate_fault_reg || otw_fault;

  // ************************************************************
  // Interrupt status
  // ************************************************************
  wire [IRQ_W-1:0] irq_event;
  assign irq_event[IRQ_OC_TRIP] = |oc_set;
  assign irq_event[IRQ_WRITE_DROP] = write_dropped;
  assign irq_event[IRQ_PUMP_UV] = pump_uv_fault;
  assign irq_event[IRQ_GATE_FAULT] = gate_set;
  assign irq_event[IRQ_OTW] = overtemp_warn_i;
  wire [IRQ_W-1:0] irq_clr = wr_icl ? wdata_i[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irq_status_next = irq_event | (irq_status_reg & ~irq_clr);

  // ************************************************************
  // Read mux
  // ************************************************************
  wire [DATA_W-1:0] rd_value =
    hit_lock ? {lock_field, lock_fault_reg} :
    hit_mode ? oc_mode_reg :
    hit_gain ? amp_gain_reg :
    hit_thr ? thresh_cal_reg :
    hit_cal ? {5'h00, amp_cal_reg} :
    hit_ist ? {3'h0, irq_status_reg} :
    hit_ien ? {3'h0, irq_enable_reg} :
    8'h00;
  wire [DATA_W-1:0] rdata_next = rd_i ? rd_value : 8'h00;

  // ************************************************************
  // Register updates
  // ************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      locked_reg <= 1'b0;
      lock_fault_reg <= RST_LOCK_FAULT[4:0];
      oc_mode_reg <= RST_OC_MODE;
      amp_gain_reg <= RST_AMP_GAIN;
      thresh_cal_reg <= RST_THRESH_CAL;
      amp_cal_reg <= RST_AMP_CAL[2:0];
    end else begin
      locked_reg <= locked_next;
      if (wr_lock_cfg) begin
        lock_fault_reg <= wdata_i[4:0];
      end
      if (wr_mode) begin
        oc_mode_reg <= wdata_i;
      end
      if (wr_gain) begin
        amp_gain_reg <= gain_wdata;
      end
      if (wr_thr) begin
        thresh_cal_reg <= wdata_i;
      end
      if (wr_cal) begin
        amp_cal_reg <= wdata_i[CAL_MSB:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_status_reg <= RST_IRQ;
      irq_enable_reg <= RST_IRQ;
      rdata_reg <= 8'h00;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_ien) begin
        irq_enable_reg <= wdata_i[IRQ_W-1:0];
      end
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_prev_reg <= 3'h0;
      oc_fault_reg <= 6'h00;
      gate_fault_reg <= 1'b0;
      retry_cnt_reg <= '0;
    end else begin
      pwm_prev_reg <= pwm_i;
      oc_fault_reg <= oc_fault_next;
      gate_fault_reg <= gate_fault_next;
      retry_cnt_reg <= retry_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rdata_o = rdata_reg;
  assign locked_o = locked_reg;
  assign oc_fault_o = oc_fault_reg;
  assign fault_output_pin_n_o = !fault_any;
  assign gate_shutdown_o = (any_oc && oc_acts) || pump_uv_fault || gate_fault_reg;
  assign drain_source_monitor_en_o = ~ds_off;
  assign irq_o = |(irq_status_reg & irq_enable_reg);

  assign sense_cfg_o.low_side_ground_reference = amp_gain_reg[LS_GND_REF_BIT];
  assign sense_cfg_o.sense_input_from_drain = amp_gain_reg[SENSE_DRAIN_BIT];
  assign sense_cfg_o.amp_gain_c = amp_gain_reg[5:4];
  assign sense_cfg_o.amp_gain_b = amp_gain_reg[3:2];
  assign sense_cfg_o.amp_gain_a = amp_gain_reg[1:0];
  assign sense_cfg_o.cal_auto_mode = cal_auto;
  assign sense_cfg_o.ref_half = thresh_cal_reg[REF_DIV_BIT];
  assign sense_cfg_o.sense_trip_level_c = thresh_cal_reg[5:4];
  assign sense_cfg_o.sense_trip_level_b = thresh_cal_reg[3:2];
  assign sense_cfg_o.sense_trip_level_a = thresh_cal_reg[1:0];

  assign amp_short_inputs_o = cal_auto ? 3'h0 : amp_cal_reg;
  assign amp_auto_cal_start_o = cal_auto ? amp_cal_reg : 3'h0;

endmodule

// File: sim/gdpc_regs_asserts.sv
// Port checks for the protection register bank
`timescale 1ns/100ps
module gdpc_regs_chk
  import gdpc_pkg::*;
#(
  parameter int RETRY_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [2:0] drain_source_overcurrent_i,
  input wire logic [5:0] oc_fault_o,
  input wire logic [2:0] drain_source_monitor_en_o,
  input wire gdpc_sense_cfg_t sense_cfg_o,
  input wire logic [2:0] amp_short_inputs_o,
  input wire logic [2:0] amp_auto_cal_start_o,
  input wire logic locked_o
);
  // ************************************************************
  // Run length of phase A overcurrent
  // ************************************************************
  logic [11:0] run_reg;
  logic [11:0] run_next;
  wire lock_wr = wr_i && addr_i == OFS_LOCK_FAULT;
  assign run_next = !drain_source_overcurrent_i[0] ? 12'h000 : (&run_reg ? run_reg : run_reg + 12'h001);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_reg <= 12'h000;
    end else begin
      run_reg <= run_next;
    end
  end
  sequence lock_s;
    lock_wr && wdata_i[7:5] == LOCK_CODE;
  endsequence
  sequence unlock_s;
    locked_o && lock_wr && wdata_i[7:5] == UNLOCK_CODE;
  endsequence
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_LOCK_SET: assert property (lock_s |=> locked_o) else $error("lock code ignored");
  AST_UNLOCK: assert property (unlock_s |=> !locked_o) else $error("unlock code ignored");
  AST_LOCK_OTHER: assert property (lock_wr && wdata_i[7:5] != LOCK_CODE && wdata_i[7:5] != UNLOCK_CODE
    |=> $stable(locked_o)) else $error("lock state moved");
  AST_LOCK_DROP: assert property (locked_o && wr_i && addr_i == OFS_OC_MODE
    |=> $stable(drain_source_monitor_en_o)) else $error("locked write taken");
  AST_DS_READ: assert property (rd_i && addr_i == OFS_OC_MODE
    |=> rdata_o[4:2] == ~drain_source_monitor_en_o) else $error("monitor enables disagree");
  AST_DRAIN_REF: assert property (sense_cfg_o.sense_input_from_drain
    |-> sense_cfg_o.low_side_ground_reference) else $error("ground reference not forced");
  AST_CAL_ROUTE: assert property ((sense_cfg_o.cal_auto_mode ? amp_short_inputs_o : amp_auto_cal_start_o)
    == 3'h0) else $error("calibration bits misrouted");
  AST_DEGLITCH: assert property ($rose(oc_fault_o[0]) |-> run_reg >= 12'h0FA)
    else $error("overcurrent fault too early");
endmodule

bind gdpc_regs gdpc_regs_chk #(.RETRY_CYCLES(RETRY_CYCLES)) i_chk (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .drain_source_overcurrent_i, .oc_fault_o, .drain_source_monitor_en_o, .sense_cfg_o,
  .amp_short_inputs_o, .amp_auto_cal_start_o, .locked_o);

// File: sim/gdpc_fet_model.sv
// Power stage model raising overcurrent flags for a set run
`timescale 1ns/100ps
module gdpc_fet_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  input wire logic [11:0] len_i,
  input wire logic [2:0] ds_sel_i,
  input wire logic [2:0] rs_sel_i,
  output logic [2:0] ds_oc_o,
  output logic [2:0] rs_oc_o
);
  logic [11:0] cnt_reg;
  wire on = cnt_reg != 12'h000;
  assign ds_oc_o = on ? ds_sel_i : 3'h0;
  assign rs_oc_o = on ? rs_sel_i : 3'h0;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 12'h000;
    end else if (go_i) begin
      cnt_reg <= len_i;
    end else if (on) begin
      cnt_reg <= cnt_reg - 12'h001;
    end
  end
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the protection register bank
`timescale 1ns/100ps
module tb_top
  import gdpc_pkg::*;
;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] pwm_i = 3'h0;
  logic pump_uv = 1'b0;
  logic gate_flt = 1'b0;
  logic otw = 1'b0;
  logic go = 1'b0;
  logic [11:0] len = 12'h000;
  logic [2:0] ds_sel = 3'h1;
  logic [2:0] rs_sel = 3'h0;
  logic [2:0] ds_oc, rs_oc, ds_en, cal_sh, cal_au;
  logic [7:0] rdata_o;
  logic [7:0] rv;
  logic pin_n, shut, locked_o, irq_o;
  logic [5:0] oc_fault_o;
  gdpc_sense_cfg_t cfg;
  int n_mismatch = 0;
  int n_compared = 0;
  int dg[8] = '{250, 475, 675, 875, 1025, 1150, 1650, 2050};
  logic [7:0] ofs[4] = '{8'h0D, 8'h0E, 8'h0F, 8'h10};
  logic [7:0] rst[4] = '{8'h61, 8'h00, 8'h2A, 8'h7F};
  gdpc_regs #(.RETRY_CYCLES(20)) i_dut (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .drain_source_overcurrent_i(ds_oc), .resistor_overcurrent_i(rs_oc), .pwm_i, .pump_undervolt_i(pump_uv),
    .gate_fault_i(gate_flt), .overtemp_warn_i(otw), .fault_output_pin_n_o(pin_n), .gate_shutdown_o(shut),
    .oc_fault_o, .drain_source_monitor_en_o(ds_en), .sense_cfg_o(cfg), .amp_short_inputs_o(cal_sh),
    .amp_auto_cal_start_o(cal_au), .locked_o, .irq_o);
  gdpc_fet_model i_fet (.clk_i, .nrst_i, .go_i(go), .len_i(len), .ds_sel_i(ds_sel), .rs_sel_i(rs_sel),
    .ds_oc_o(ds_oc), .rs_oc_o(rs_oc));
  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(16'(rdata_o), 16'(exp));
  endtask
  task automatic oc(input int n);
    @(posedge clk_i);
    go <= 1'b1;
    len <= 12'(n);
    @(posedge clk_i);
    go <= 1'b0;
    tk(n + 1);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    tk(100000);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    tk(2);
    for (int i = 0; i < 4; i++) begin
      rc(ofs[i], rst[i]);
    end
    chk(16'(cfg), 16'h2A7F);
    rc(8'h30, 8'h00);
    $display("reset done");
    wr(OFS_OC_MODE, 8'h1C);
    chk(16'(ds_en), 16'h0000);
    wr(OFS_AMP_GAIN, 8'h40);
    rc(OFS_AMP_GAIN, 8'hC0);
    wr(OFS_AMP_CAL, 8'h07);
    chk(16'({cal_sh, cal_au}), 16'h0038);
    wr(OFS_THRESH_CAL, 8'h80);
    chk(16'({cal_sh, cal_au}), 16'h0007);
    chk(16'(cfg[7:0]), 16'h0080);
    for (int k = 0; k < 4; k++) begin
      rv = 8'h15 * 8'(k);
      wr(OFS_AMP_GAIN, rv);
      wr(OFS_THRESH_CAL, rv);
      rc(OFS_AMP_GAIN, rv);
      rc(OFS_THRESH_CAL, rv);
    end
    wr(OFS_LOCK_FAULT, 8'h60);
    oc(250);
    chk(16'(oc_fault_o), 16'h0000);
    $display("field done");
    wr(OFS_OC_MODE, 8'h00);
    oc(250);
    chk(16'({oc_fault_o, irq_o}), 16'h0002);
    rc(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_IRQ_ENABLE, 8'h01);
    chk(16'(irq_o), 16'h0001);
    wr(OFS_FAULT_CLEAR, 8'h80);
    wr(OFS_IRQ_CLEAR, 8'h01);
    chk(16'({oc_fault_o, irq_o}), 16'h0000);
    wr(OFS_IRQ_ENABLE, 8'h00);
    $display("interrupt done");
    for (int c = 0; c < 8; c++) begin
      wr(OFS_LOCK_FAULT, 8'h60 | 8'(c));
      oc(dg[c] - 1);
      chk(16'(oc_fault_o), 16'h0000);
      oc(dg[c]);
      chk(16'(oc_fault_o), 16'h0001);
      wr(OFS_FAULT_CLEAR, 8'h80);
    end
    wr(OFS_LOCK_FAULT, 8'h60);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_OC_MODE, 8'(m));
      oc(250);
      chk(16'({oc_fault_o, shut, pin_n}), 16'({m != 3, m < 2, m == 3}));
      if (m == 1) begin
        tk(25);
        chk(16'(oc_fault_o), 16'h0000);
      end
      wr(OFS_FAULT_CLEAR, 8'h80);
    end
    wr(OFS_OC_MODE, 8'h21);
    ds_sel <= 3'h0;
    rs_sel <= 3'h2;
    oc(250);
    chk(16'(oc_fault_o), 16'h0010);
    pwm_i <= 3'h4;
    tk(3);
    chk(16'(oc_fault_o), 16'h0000);
    pwm_i <= 3'h0;
    ds_sel <= 3'h1;
    rs_sel <= 3'h0;
    $display("overcurrent done");
    wr(OFS_OC_MODE, 8'h00);
    pump_uv <= 1'b1;
    tk(1);
    chk(16'(pin_n), 16'h0000);
    wr(OFS_LOCK_FAULT, 8'h70);
    chk(16'(pin_n), 16'h0001);
    pump_uv <= 1'b0;
    wr(OFS_LOCK_FAULT, 8'h68);
    gate_flt <= 1'b1;
    tk(2);
    chk(16'(pin_n), 16'h0001);
    wr(OFS_LOCK_FAULT, 8'h60);
    tk(2);
    chk(16'(pin_n), 16'h0000);
    gate_flt <= 1'b0;
    wr(OFS_FAULT_CLEAR, 8'h80);
    tk(1);
    chk(16'(pin_n), 16'h0001);
    otw <= 1'b1;
    tk(1);
    chk(16'(pin_n), 16'h0001);
    wr(OFS_OC_MODE, 8'h40);
    chk(16'(pin_n), 16'h0000);
    otw <= 1'b0;
    $display("fault pin done");
    wr(OFS_OC_MODE, 8'h00);
    wr(OFS_LOCK_FAULT, 8'hC0);
    rc(OFS_LOCK_FAULT, 8'hC0);
    wr(OFS_OC_MODE, 8'h1C);
    rc(OFS_OC_MODE, 8'h00);
    rc(OFS_IRQ_STATUS, 8'h1F);
    wr(OFS_LOCK_FAULT, 8'h1F);
    rc(OFS_LOCK_FAULT, 8'hC0);
    oc(250);
    chk(16'(oc_fault_o), 16'h0001);
    wr(OFS_FAULT_CLEAR, 8'h80);
    chk(16'(oc_fault_o), 16'h0000);
    wr(OFS_LOCK_FAULT, 8'h60);
    rc(OFS_LOCK_FAULT, 8'h60);
    wr(OFS_LOCK_FAULT, 8'hA0);
    chk(16'(locked_o), 16'h0000);
    $display("lock done");
    wrap_up();
  end
endmodule
